// >>> rtl/sps_pkg.sv
// Purpose: shared constants for the system pin select block
// Assumes: master clock at 100 MHz, slow clock at 32768 Hz
// Notes:   select bit set means the line is a general port line
package sps_pkg;

    // ----------------------------------------------------------------
    // line map
    // ----------------------------------------------------------------
    localparam int          LINE_W     = 16;
    localparam logic [15:0] SEL_MASK   = 16'h1CF0;
    localparam logic [15:0] SEL_RESET  = 16'h0000;
    localparam int          BIT_TDI    = 4;
    localparam int          BIT_TDO    = 5;
    localparam int          BIT_TMS    = 6;
    localparam int          BIT_TCK    = 7;
    localparam int          BIT_DM     = 10;
    localparam int          BIT_DP     = 11;
    localparam int          BIT_WIPE   = 12;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int MCLK_PERIOD_NS   = 10;
    localparam int SLOW_CLK_HZ      = 32768;
    localparam int IGNORE_MS        = 100;
    localparam int ACCEPT_MS        = 220;
    localparam int QUALIFY_MS       = 160;
    localparam int IGNORE_TICKS     = (IGNORE_MS * SLOW_CLK_HZ + 999) / 1000;
    localparam int QUALIFY_TICKS    = (QUALIFY_MS * SLOW_CLK_HZ + 999) / 1000;
    localparam int RST_PULSE_NS     = 1000;
    localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int DEB_W            = 16;
    localparam int RST_CNT_W        = 8;

    // ----------------------------------------------------------------
    // debug form switching
    // ----------------------------------------------------------------
    localparam logic [15:0] SWITCH_TO_2W   = 16'hE79E;
    localparam logic [15:0] SWITCH_TO_JTAG = 16'hE73C;
    localparam logic [31:0] ERASED_WORD    = 32'hFFFF_FFFF;

    typedef enum logic [1:0]
    {
        SPS_FORM_JTAG = 2'b01,
        SPS_FORM_2W   = 2'b10
    } sps_form_type;

endpackage

// >>> rtl/sps_system_io_pin_select.sv
// Purpose: system-function versus port-line selection for shared pins,
//          debug port form, reset pin and wipe pin handling
// Assumes: all pin inputs synchronous to mclk; slow_clk sampled as a level
// Notes:   backup region has no reset output here and is never touched
//
// Overview of operation
// - after reset every shared pin is in its system function
// - select bits 12 wipe, 10/11 usb, 7..4 debug clock/mode/out/in
// - each port line has its own output value and enable
// - pad pull, trigger and filter settings apply in either mode
// - debug port starts in boundary chain form until switch sequence seen
// - trace output drives data-out pin only in two-wire form
// - boundary scan select high routes debug pins to boundary scan
// - test pin picks scan test or fast programming; low is normal
// - reset pin bidirectional: driven low by controller, external low resets
// - external reset hits core and peripherals, not backup region
// - any external pulse accepted; driven pulse has a guaranteed minimum
// - reset pin is an input after reset
// - qualified wipe returns flash and wiped bits to all ones
// - wipe pin debounced on slow clock; highs under 160 ms ignored
// - wipe pin in port mode never starts a wipe
`timescale 1ns/10ps
module sps_system_io_pin_select
#(
    parameter int           QUALIFY_TICKS    = sps_pkg::QUALIFY_TICKS,
    parameter int           RST_PULSE_CYCLES = sps_pkg::RST_PULSE_CYCLES,
    parameter logic [15:0]  SWITCH_SEQ_2W    = sps_pkg::SWITCH_TO_2W,
    parameter logic [15:0]  SWITCH_SEQ_JTAG  = sps_pkg::SWITCH_TO_JTAG
)
(
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire logic               slow_clk,
    // select bits
    input  wire logic               sel_load,
    input  wire logic [15:0]        sel_wdata,
    output logic [15:0]             sel_bits,
    // port controller side
    input  wire logic [15:0]        port_out_val,
    input  wire logic [15:0]        port_out_en,
    input  wire logic [15:0]        port_pull_en,
    input  wire logic [15:0]        port_schmitt_en,
    input  wire logic [15:0]        port_filter_en,
    output logic [15:0]             port_in_val,
    // pads
    input  wire logic [15:0]        pad_in,
    output logic [15:0]             pad_out,
    output logic [15:0]             pad_oe,
    output logic [15:0]             pad_pull_en,
    output logic [15:0]             pad_schmitt_en,
    output logic [15:0]             pad_filter_en,
    // debug core side
    output logic                    dbg_tck,
    output logic                    dbg_tms,
    output logic                    dbg_tdi,
    input  wire logic               dbg_tdo,
    input  wire logic               dbg_tdo_en,
    input  wire logic               dbg_swdio_out,
    input  wire logic               dbg_swdio_oe,
    input  wire logic               async_trace_data,
    input  wire logic               async_trace_en,
    output logic                    two_wire_active,
    // usb transceiver side
    input  wire logic               usb_dm_out,
    input  wire logic               usb_dp_out,
    input  wire logic               usb_drive_en,
    output logic                    usb_data_minus,
    output logic                    usb_data_plus,
    // test straps
    input  wire logic               boundary_scan_select,
    input  wire logic               factory_test_pin,
    input  wire logic               strap_pa0,
    input  wire logic               strap_pa1,
    output logic                    bscan_route,
    output logic                    mfg_test_mode,
    output logic                    fast_prog_mode,
    // reset pin
    input  wire logic               external_reset_pin_in,
    output logic                    external_reset_pin_out,
    output logic                    external_reset_pin_oe,
    input  wire logic               rstc_drive_req,
    output logic                    core_periph_reset_req,
    // flash wipe
    input  wire logic               flash_wipe_done,
    output logic                    flash_wipe_start,
    output logic                    flash_wipe_busy,
    output logic [31:0]             erased_fill_word
);

    // ----------------------------------------------------------------
    // select bits
    // ----------------------------------------------------------------
    logic [15:0] sel_ff;
    wire  [15:0] nxt_sel  = sel_load ? (sel_wdata & sps_pkg::SEL_MASK) : sel_ff;
    // lines without a system function are always port lines
    wire  [15:0] port_mode = sel_ff | ~sps_pkg::SEL_MASK;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            sel_ff <= sps_pkg::SEL_RESET;
        else
            sel_ff <= nxt_sel;
    end
    assign sel_bits = sel_ff;

    // ----------------------------------------------------------------
    // debug form detection
    // ----------------------------------------------------------------
    logic                 tck_q_ff;
    logic [15:0]          seq_ff;
    sps_pkg::sps_form_type form_ff;
    sps_pkg::sps_form_type nxt_form;

    wire sys_tck  = pad_in[sps_pkg::BIT_TCK] & ~port_mode[sps_pkg::BIT_TCK];
    wire sys_tms  = pad_in[sps_pkg::BIT_TMS] & ~port_mode[sps_pkg::BIT_TMS];
    wire tck_rise = sys_tck & ~tck_q_ff;
    // sequence bits arrive least significant first
    wire [15:0] nxt_seq  = tck_rise ? {sys_tms, seq_ff[15:1]} : seq_ff;
    wire        hit_2w   = tck_rise && (nxt_seq == SWITCH_SEQ_2W);
    wire        hit_jtag = tck_rise && (nxt_seq == SWITCH_SEQ_JTAG);

    always_comb
    begin
        case (form_ff)
            sps_pkg::SPS_FORM_JTAG:
                nxt_form = hit_2w ? sps_pkg::SPS_FORM_2W : sps_pkg::SPS_FORM_JTAG;
            sps_pkg::SPS_FORM_2W:
                nxt_form = hit_jtag ? sps_pkg::SPS_FORM_JTAG : sps_pkg::SPS_FORM_2W;
            default:
                nxt_form = sps_pkg::SPS_FORM_JTAG;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tck_q_ff <= 1'b0;
            seq_ff   <= '0;
            form_ff  <= sps_pkg::SPS_FORM_JTAG;
        end
        else
        begin
            tck_q_ff <= sys_tck;
            seq_ff   <= nxt_seq;
            form_ff  <= nxt_form;
        end
    end

    wire in_2w = (form_ff == sps_pkg::SPS_FORM_2W);
    assign two_wire_active = in_2w;

    // ----------------------------------------------------------------
    // pad multiplexing
    // ----------------------------------------------------------------
    wire sys_out_5 = in_2w ? async_trace_data : dbg_tdo;
    wire sys_oe_5  = in_2w ? async_trace_en   : dbg_tdo_en;
    wire sys_oe_6  = in_2w & dbg_swdio_oe;

    logic [15:0] sys_out;
    logic [15:0] sys_oe;
    always_comb
    begin
        sys_out                    = '0;
        sys_oe                     = '0;
        sys_out[sps_pkg::BIT_TDO]  = sys_out_5;
        sys_oe[sps_pkg::BIT_TDO]   = sys_oe_5;
        sys_out[sps_pkg::BIT_TMS]  = dbg_swdio_out;
        sys_oe[sps_pkg::BIT_TMS]   = sys_oe_6;
        sys_out[sps_pkg::BIT_DM]   = usb_dm_out;
        sys_oe[sps_pkg::BIT_DM]    = usb_drive_en;
        sys_out[sps_pkg::BIT_DP]   = usb_dp_out;
        sys_oe[sps_pkg::BIT_DP]    = usb_drive_en;
    end

    // per-line choice between port controller and system function
    wire [15:0] nxt_pad_out = (port_mode & port_out_val) | (~port_mode & sys_out);
    wire [15:0] nxt_pad_oe  = (port_mode & port_out_en)  | (~port_mode & sys_oe);

    logic [15:0] pad_out_ff;
    logic [15:0] pad_oe_ff;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pad_out_ff <= '0;
            pad_oe_ff  <= '0;
        end
        else
        begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_ff  <= nxt_pad_oe;
        end
    end
    assign pad_out = pad_out_ff;
    assign pad_oe  = pad_oe_ff;

    // pad conditioning follows the port controller in both modes
    assign pad_pull_en    = port_pull_en;
    assign pad_schmitt_en = port_schmitt_en;
    assign pad_filter_en  = port_filter_en;

    assign port_in_val    = pad_in & port_mode;
    assign dbg_tck        = sys_tck;
    assign dbg_tms        = sys_tms;
    assign dbg_tdi        = pad_in[sps_pkg::BIT_TDI] & ~port_mode[sps_pkg::BIT_TDI];
    assign usb_data_minus = pad_in[sps_pkg::BIT_DM] & ~port_mode[sps_pkg::BIT_DM];
    assign usb_data_plus  = pad_in[sps_pkg::BIT_DP] & ~port_mode[sps_pkg::BIT_DP];

    // ----------------------------------------------------------------
    // test straps
    // ----------------------------------------------------------------
    assign bscan_route    = boundary_scan_select;
    assign fast_prog_mode = factory_test_pin & ~strap_pa0 & ~strap_pa1;
    assign mfg_test_mode  = factory_test_pin & ~fast_prog_mode;

    // ----------------------------------------------------------------
    // reset pin
    // ----------------------------------------------------------------
    logic [sps_pkg::RST_CNT_W-1:0] rst_cnt_ff;
    logic                          core_rst_ff;
    wire  driving = (rst_cnt_ff != '0);
    wire  [sps_pkg::RST_CNT_W-1:0] nxt_rst_cnt =
        rstc_drive_req ? sps_pkg::RST_CNT_W'(RST_PULSE_CYCLES) :
        (driving ? rst_cnt_ff - 1'b1 : rst_cnt_ff);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_cnt_ff  <= '0;
            core_rst_ff <= 1'b0;
        end
        else
        begin
            rst_cnt_ff  <= nxt_rst_cnt;
            core_rst_ff <= ~external_reset_pin_in;
        end
    end
    assign external_reset_pin_oe  = driving;
    assign external_reset_pin_out = 1'b0;
    // only core and peripherals take this request, never the backup region
    assign core_periph_reset_req  = core_rst_ff;

    // ----------------------------------------------------------------
    // flash wipe
    // ----------------------------------------------------------------
    logic slow_q_ff;
    logic wipe_start_ff;
    logic wipe_busy_ff;
    logic wipe_qual;
    wire  slow_tick  = slow_clk & ~slow_q_ff;
    wire  wipe_level = pad_in[sps_pkg::BIT_WIPE] & ~port_mode[sps_pkg::BIT_WIPE];

    sps_wipe_debounce #(
        .QUALIFY_TICKS (QUALIFY_TICKS)
    ) u_debounce (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .slow_tick (slow_tick),
        .level     (wipe_level),
        .qualified (wipe_qual),
        .count     ()
    );

    wire nxt_busy = wipe_qual | (wipe_busy_ff & ~flash_wipe_done);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slow_q_ff     <= 1'b0;
            wipe_start_ff <= 1'b0;
            wipe_busy_ff  <= 1'b0;
        end
        else
        begin
            slow_q_ff     <= slow_clk;
            wipe_start_ff <= wipe_qual & ~wipe_busy_ff;
            wipe_busy_ff  <= nxt_busy;
        end
    end
    assign flash_wipe_start = wipe_start_ff;
    assign flash_wipe_busy  = wipe_busy_ff;
    assign erased_fill_word = sps_pkg::ERASED_WORD;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence drive_req_s;
        rstc_drive_req ##1 1'b1;
    endsequence
    sequence drive_hold_s;
        external_reset_pin_oe [*8];
    endsequence

    sel_start_a: assert property ($rose(reset_n) |-> sel_ff == '0)
        else $error("select bits not in system function after reset");
    line_map_a: assert property (sel_ff[12] |=> !wipe_start_ff)
        else $error("wipe started while wipe pin is a port line");
    port_mux_a: assert property (port_mode[3] |=> pad_oe[3] == $past(port_out_en[3]))
        else $error("port line enable not passed through");
    trace_gate_a: assert property (!in_2w && !sel_ff[5] |=>
        pad_oe[5] == $past(dbg_tdo_en))
        else $error("trace drove data-out pin in boundary chain form");
    form_start_a: assert property ($rose(reset_n) |-> form_ff == sps_pkg::SPS_FORM_JTAG)
        else $error("debug port did not start in boundary chain form");
    form_switch_a: assert property (hit_2w && !in_2w |=> in_2w)
        else $error("switch sequence did not enable two-wire form");
    scan_route_a: assert property (bscan_route == boundary_scan_select)
        else $error("boundary scan routing wrong");
    test_mode_a: assert property (!factory_test_pin |-> !mfg_test_mode && !fast_prog_mode)
        else $error("test mode active with test pin low");
    rst_pulse_a: assert property (drive_req_s |-> drive_hold_s)
        else $error("reset pin driven pulse too short");
    rst_in_a: assert property (!external_reset_pin_in |=> core_periph_reset_req)
        else $error("external reset not passed to core");
    wipe_busy_a: assert property (wipe_start_ff |-> wipe_busy_ff)
        else $error("wipe start without busy");

endmodule // sps_system_io_pin_select

// >>> rtl/sps_wipe_debounce.sv
// Purpose: slow-clock debounce and qualification of the wipe pin level
// Assumes: slow_tick is a one-cycle pulse per slow clock period
// Notes:   counter restarts on any low sample, fires once per high period
`timescale 1ns/10ps
module sps_wipe_debounce
#(
    parameter int QUALIFY_TICKS = sps_pkg::QUALIFY_TICKS
)
(
    input  wire logic                      mclk,
    input  wire logic                      reset_n,
    input  wire logic                      slow_tick,
    input  wire logic                      level,
    output logic                           qualified,
    output logic [sps_pkg::DEB_W-1:0]      count
);

    localparam logic [sps_pkg::DEB_W-1:0] LAST = sps_pkg::DEB_W'(QUALIFY_TICKS - 1);
    localparam logic [sps_pkg::DEB_W-1:0] FULL = sps_pkg::DEB_W'(QUALIFY_TICKS);

    logic [sps_pkg::DEB_W-1:0] count_ff;
    logic [sps_pkg::DEB_W-1:0] nxt_count;
    logic                      qual_ff;
    wire                       step = slow_tick && (count_ff != FULL);

    // restart on low, count slow ticks while high, saturate at threshold
    assign nxt_count = !level ? '0 : (step ? count_ff + 1'b1 : count_ff);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_ff <= '0;
            qual_ff  <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            qual_ff  <= level && slow_tick && (count_ff == LAST);
        end
    end

    assign qualified = qual_ff;
    assign count     = count_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    low_restart_a: assert property (!level |=> count_ff == '0)
        else $error("debounce count did not restart on low level");
    short_high_a: assert property (qual_ff |-> $past(count_ff) == LAST)
        else $error("wipe qualified before threshold was reached");

endmodule // sps_wipe_debounce

// >>> tb/sps_probe_model.sv
// Purpose: debug probe, wipe fixture and slow clock source for the bench
// Assumes: everything changes on falling mclk edges
// Notes:   slow clock rises once every 8 mclk cycles; wipe line has a pull-down
`timescale 1ns/10ps
module sps_probe_model
(
    input  wire logic mclk,
    output logic      slow_clk,
    output logic      probe_tck,
    output logic      probe_tms,
    output logic      wipe_level
);
    initial
    begin
        slow_clk   = 1'b0;
        probe_tck  = 1'b0;
        probe_tms  = 1'b0;
        wipe_level = 1'b0; // board keeps the wipe line low at startup
        forever
        begin
            repeat (4) @(negedge mclk);
            slow_clk = ~slow_clk;
        end
    end

    // ------------------------------------------------------------
    // switch word on the mode line, lsb first, one bit per clock rise
    // ------------------------------------------------------------
    task automatic send_word(input logic [15:0] w);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge mclk);
            probe_tck = 1'b0;
            @(negedge mclk);
            probe_tck = 1'b1;
            probe_tms = w[i];
        end
        @(negedge mclk);
        probe_tck = 1'b0;
        probe_tms = ~w[15]; // released line must not keep the last bit
    endtask

    // ------------------------------------------------------------
    // hold the wipe line high for a number of slow clock rises
    // ------------------------------------------------------------
    task automatic hold_wipe(input int ticks);
        @(posedge slow_clk);
        @(negedge mclk);
        wipe_level = 1'b1;
        repeat (ticks) @(posedge slow_clk);
        @(negedge mclk);
        wipe_level = 1'b0;
    endtask
endmodule // sps_probe_model

// >>> tb/testbench.sv
// Purpose: self-checking bench for the system pin select block
// Assumes: probe model drives pads 6, 7, 12 and the slow clock
// Notes:   short counts: qualify after 3 ticks, reset drive of 8 cycles
`timescale 1ns/10ps
module testbench;
    localparam int RC = 8;
    logic        reset_n = 1'b0, sel_load = 1'b0, ext_low = 1'b0, mclk = 1'b0;
    logic        dbg_tdo = 1'b0, dbg_tdo_en = 1'b0, dbg_swdio_out = 1'b0, dbg_swdio_oe = 1'b0;
    logic        async_trace_data = 1'b0, async_trace_en = 1'b0, rstc_drive_req = 1'b0;
    logic        usb_dm_out = 1'b0, usb_dp_out = 1'b0, usb_drive_en = 1'b0;
    logic        boundary_scan_select = 1'b0, factory_test_pin = 1'b0;
    logic        strap_pa0 = 1'b0, strap_pa1 = 1'b0, flash_wipe_done = 1'b0;
    logic [15:0] sel_wdata = 16'h0000, port_out_val = 16'h0000, port_out_en = 16'h0000;
    logic [15:0] port_pull_en = 16'h00FF, port_schmitt_en = 16'h0F00, port_filter_en = 16'h3000;
    logic [15:0] pad_tb = 16'h3C5A;
    logic [31:0] starts = 32'h0000_0000;
    logic [31:0] n;
    int          err_total = 0;
    int          tests_run = 0;
    wire logic   slow_clk, probe_tck, probe_tms, wipe_level, external_reset_pin_in;
    wire logic [15:0] pad_in;
    logic [15:0] sel_bits, port_in_val, pad_out, pad_oe, pad_pull_en, pad_schmitt_en, pad_filter_en;
    logic        dbg_tck, dbg_tms, dbg_tdi, two_wire_active, usb_data_minus, usb_data_plus;
    logic        bscan_route, mfg_test_mode, fast_prog_mode, external_reset_pin_out;
    logic        external_reset_pin_oe, core_periph_reset_req, flash_wipe_start, flash_wipe_busy;
    logic [31:0] erased_fill_word;

    // pin has a pull-up; either side may pull it low
    assign external_reset_pin_in = ~ext_low & ~(external_reset_pin_oe & ~external_reset_pin_out);
    assign pad_in = (pad_tb & 16'hEF3F) | {3'b000, wipe_level, 4'h0, probe_tck, probe_tms, 6'h00};

    initial
    begin
        forever
        begin
            #5 mclk = ~mclk;
        end
    end

    always @(posedge mclk)
    begin
        if (flash_wipe_start === 1'b1)
            starts <= starts + 32'h0000_0001;
    end

    sps_probe_model probe (.mclk(mclk), .slow_clk(slow_clk), .probe_tck(probe_tck),
        .probe_tms(probe_tms), .wipe_level(wipe_level));

    sps_system_io_pin_select #(.QUALIFY_TICKS(3), .RST_PULSE_CYCLES(RC)) uut (
        .mclk(mclk), .reset_n(reset_n), .slow_clk(slow_clk), .sel_load(sel_load),
        .sel_wdata(sel_wdata), .sel_bits(sel_bits), .port_out_val(port_out_val),
        .port_out_en(port_out_en), .port_pull_en(port_pull_en), .port_schmitt_en(port_schmitt_en),
        .port_filter_en(port_filter_en), .port_in_val(port_in_val), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
        .pad_schmitt_en(pad_schmitt_en), .pad_filter_en(pad_filter_en), .dbg_tck(dbg_tck),
        .dbg_tms(dbg_tms), .dbg_tdi(dbg_tdi), .dbg_tdo(dbg_tdo), .dbg_tdo_en(dbg_tdo_en),
        .dbg_swdio_out(dbg_swdio_out), .dbg_swdio_oe(dbg_swdio_oe),
        .async_trace_data(async_trace_data), .async_trace_en(async_trace_en),
        .two_wire_active(two_wire_active), .usb_dm_out(usb_dm_out), .usb_dp_out(usb_dp_out),
        .usb_drive_en(usb_drive_en), .usb_data_minus(usb_data_minus),
        .usb_data_plus(usb_data_plus), .boundary_scan_select(boundary_scan_select),
        .factory_test_pin(factory_test_pin), .strap_pa0(strap_pa0), .strap_pa1(strap_pa1),
        .bscan_route(bscan_route), .mfg_test_mode(mfg_test_mode),
        .fast_prog_mode(fast_prog_mode), .external_reset_pin_in(external_reset_pin_in),
        .external_reset_pin_out(external_reset_pin_out),
        .external_reset_pin_oe(external_reset_pin_oe), .rstc_drive_req(rstc_drive_req),
        .core_periph_reset_req(core_periph_reset_req), .flash_wipe_done(flash_wipe_done),
        .flash_wipe_start(flash_wipe_start), .flash_wipe_busy(flash_wipe_busy),
        .erased_fill_word(erased_fill_word));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic load_sel(input logic [15:0] v);
        sel_wdata = v;
        sel_load = 1'b1;
        @(negedge mclk);
        sel_load = 1'b0;
        @(negedge mclk);
    endtask

    task automatic end_sim();
        $display("counts: %0d compares, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        chk("sel_bits", 16'h0000, sel_bits);
        chk("rst_oe", 1'b0, external_reset_pin_oe);
        chk("two_wire", 1'b0, two_wire_active);
        chk("fill", 32'hFFFF_FFFF, erased_fill_word);
        chk("dbg_tdi", pad_tb[4], dbg_tdi);
        chk("usb_in", 2'b11, {usb_data_plus, usb_data_minus});
        $display("test reset done");
        load_sel(16'hFFFF);
        chk("sel_bits", 16'h1CF0, sel_bits);
        chk("sys_in_port", 3'b000, {usb_data_plus, usb_data_minus, dbg_tdi});
        port_out_val = 16'hA5C3;
        port_out_en = 16'h5AF0;
        @(negedge mclk);
        chk("pad_out", 16'hA5C3, pad_out);
        chk("pad_oe", 16'h5AF0, pad_oe);
        chk("port_in", pad_tb & 16'hEF3F, port_in_val);
        chk("pull", port_pull_en, pad_pull_en);
        chk("trig_filt", {port_schmitt_en, port_filter_en}, {pad_schmitt_en, pad_filter_en});
        $display("test port done");
        load_sel(16'h0000);
        port_out_en = 16'h0000;
        usb_drive_en = 1'b1;
        async_trace_en = 1'b1;
        async_trace_data = 1'b1;
        port_pull_en = 16'hF00F;
        port_schmitt_en = 16'h00F0;
        port_filter_en = 16'h0C03;
        @(negedge mclk);
        chk("usb_oe", 2'b11, pad_oe[11:10]);
        chk("pull", port_pull_en, pad_pull_en);
        chk("trig_filt", {port_schmitt_en, port_filter_en}, {pad_schmitt_en, pad_filter_en});
        chk("trace_oe", 1'b0, pad_oe[5]);
        probe.send_word(sps_pkg::SWITCH_TO_2W);
        @(negedge mclk);
        chk("two_wire", 1'b1, two_wire_active);
        chk("trace_oe", 1'b1, pad_oe[5]);
        chk("trace_out", 1'b1, pad_out[5]);
        probe.send_word(sps_pkg::SWITCH_TO_JTAG);
        @(negedge mclk);
        chk("two_wire", 1'b0, two_wire_active);
        chk("trace_oe", 1'b0, pad_oe[5]);
        $display("test debug done");
        for (int i = 0; i < 8; i++)
        begin
            {factory_test_pin, strap_pa0, strap_pa1} = i[2:0];
            boundary_scan_select = i[0];
            @(negedge mclk);
            chk("fast", i == 4, fast_prog_mode);
            chk("mfg", i > 4, mfg_test_mode);
            chk("bscan", i[0], bscan_route);
        end
        {factory_test_pin, strap_pa0, strap_pa1, boundary_scan_select} = 4'h0;
        $display("test straps done");
        @(negedge mclk);
        rstc_drive_req = 1'b1;
        @(negedge mclk);
        rstc_drive_req = 1'b0;
        n = 32'h0000_0000;
        repeat (20)
        begin
            n = n + {31'h0000_0000, external_reset_pin_oe};
            @(negedge mclk);
        end
        chk("drive_len", RC, n);
        chk("pin_out", 1'b0, external_reset_pin_out);
        ext_low = 1'b1;
        @(negedge mclk);
        ext_low = 1'b0;
        chk("core_rst", 1'b1, core_periph_reset_req);
        @(negedge mclk);
        chk("core_rst", 1'b0, core_periph_reset_req);
        $display("test reset pin done");
        probe.hold_wipe(2);
        repeat (3) @(negedge mclk);
        chk("short_high", 0, starts);
        probe.hold_wipe(6);
        repeat (3) @(negedge mclk);
        chk("long_high", 1, starts);
        chk("busy", 1'b1, flash_wipe_busy);
        flash_wipe_done = 1'b1;
        @(negedge mclk);
        flash_wipe_done = 1'b0;
        @(negedge mclk);
        chk("busy", 1'b0, flash_wipe_busy);
        load_sel(16'h1000);
        probe.hold_wipe(6);
        repeat (3) @(negedge mclk);
        chk("port_wipe", 1, starts);
        $display("test wipe done");
        end_sim();
    end
endmodule // testbench
